// file: doc_pkg.sv
// constants shared by the converter output control block
// assumes a 32-bit byte-addressed register port and a 10-bit converter input
package doc_pkg;

    // ======================================================================
    // register byte addresses
    localparam logic [31:0] DOC_ADDR_SAMPLE = 32'hFFFF06B4;
    localparam logic [31:0] DOC_ADDR_SOURCE = 32'hFFFF06B8;
    localparam logic [31:0] DOC_ADDR_CONTROL = 32'hFFFF06BC;
    localparam logic [31:0] DOC_ADDR_KEY_FIRST = 32'hFFFF06C0;
    localparam logic [31:0] DOC_ADDR_KEY_SECOND = 32'hFFFF06C4;
    localparam logic [31:0] DOC_ADDR_STATUS = 32'hFFFF06C8;

    // ======================================================================
    // unlock keys
    localparam logic [7:0] DOC_KEY_FIRST_VAL = 8'h07;
    localparam logic [7:0] DOC_KEY_SECOND_VAL = 8'hB9;

    // ======================================================================
    // converter_control layout
    localparam int DOC_CTL_W = 11;
    localparam int DOC_CTL_OE_BIT = 5;
    localparam int DOC_CTL_DIFF_BIT = 4;
    localparam int DOC_CTL_MODE_HI = 2;
    localparam int DOC_CTL_MODE_LO = 1;
    localparam int DOC_CTL_RATE_BIT = 0;
    localparam logic [10:0] DOC_CTL_WR_MASK = 11'h037;
    localparam logic [10:0] DOC_CTL_RESET = 11'h000;
    localparam logic [1:0] DOC_MODE_POWER_DOWN = 2'h0;
    localparam logic [1:0] DOC_MODE_ACTIVE = 2'h3;

    // ======================================================================
    // converter_source_select and converter_sample_word layout
    localparam int DOC_SRC_W = 8;
    localparam int DOC_SRC_SOFT_BIT = 0;
    localparam logic [7:0] DOC_SRC_RESET = 8'h00;
    localparam int DOC_SAMPLE_W = 10;
    localparam logic [9:0] DOC_SAMPLE_RESET = 10'h000;
    localparam int DOC_SAMPLE_SIGN_BIT = 9;
    localparam logic [9:0] DOC_CODE_RESET = 10'h200;

    // ======================================================================
    // status register layout
    localparam int DOC_STAT_ARMED_BIT = 16;
    localparam int DOC_STAT_HELD_BIT = 17;
    localparam int DOC_STAT_ACTIVE_BIT = 18;

    // ======================================================================
    // unlock sequence states
    typedef enum logic [2:0] {
        DOC_KEY_IDLE = 3'h1,
        DOC_KEY_ARMED = 3'h2,
        DOC_KEY_HELD = 3'h4
    } doc_key_e;

endpackage

// file: doc_edge_sync.sv
// two-flop synchroniser with falling-edge pulse for a foreign-domain level
// assumes the reset given is already synchronous to clk_sys on release
`timescale 1ns/1ps
module doc_edge_sync (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_sync_b,
    // level from outside the clock domain
    input wire logic level_async,
    // one-cycle pulse after a high-to-low change
    output logic fall_q
);

    logic meta_q;
    logic sync_q;
    logic prev_q;

    // ======================================================================
    // synchroniser: meta_q feeds sync_q only
    always_ff @(posedge clk_sys or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            meta_q <= 1'b0;
            sync_q <= 1'b0;
            prev_q <= 1'b0;
        end else begin
            meta_q <= level_async;
            sync_q <= meta_q;
            prev_q <= sync_q;
        end
    end

    // ======================================================================
    // edge detect
    always_ff @(posedge clk_sys or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            fall_q <= 1'b0;
        end else begin
            fall_q <= prev_q & ~sync_q;
        end
    end

endmodule

// file: doc_top.sv
// converter output control: register port, unlock sequence, sample routing
// assumes timer_level comes from another clock and synth samples from clk_sys
`timescale 1ns/1ps
module doc_top (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_b,
    // register port
    input wire logic [31:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata_q,
    // update source and synthesizer samples
    input wire logic timer_level,
    input wire logic [9:0] synth_sample,
    input wire logic synth_valid,
    // converter and line driver controls
    output logic [9:0] conv_code_q,
    output logic conv_power_q,
    output logic line_pos_oe_q,
    output logic line_neg_oe_q
);
    import doc_pkg::*;

    // ======================================================================
    // functions
    function automatic logic addr_is(input logic [31:0] a, input logic [31:0] r);
        return a == r;
    endfunction

    // signed sample to straight binary for the current-output stage
    function automatic logic [9:0] to_code(input logic [9:0] s);
        logic [9:0] c;
        c = s;
        c[DOC_SAMPLE_SIGN_BIT] = ~s[DOC_SAMPLE_SIGN_BIT];
        return c;
    endfunction

    // ======================================================================
    // reset release
    logic rst_meta_b_q;
    logic rst_sync_b_q;

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            rst_meta_b_q <= 1'b0;
            rst_sync_b_q <= 1'b0;
        end else begin
            rst_meta_b_q <= 1'b1;
            rst_sync_b_q <= rst_meta_b_q;
        end
    end

    // ======================================================================
    // declarations
    logic [10:0] ctl_q;
    logic [7:0] source_q;
    logic [9:0] sample_q;
    doc_key_e key_q;
    logic pend_is_sample_q;
    logic [DOC_SAMPLE_W-1:0] pend_data_q;
    logic commit_c;
    logic timer_fall;
    logic mode_active;
    logic soft_sel;
    logic soft_tick;

    assign mode_active = ctl_q[DOC_CTL_MODE_HI:DOC_CTL_MODE_LO] == DOC_MODE_ACTIVE;
    assign soft_sel = source_q[DOC_SRC_SOFT_BIT];
    // bus-clock rate loads every cycle; timer rate waits for its falling edge
    assign soft_tick = ctl_q[DOC_CTL_RATE_BIT] ? timer_fall : 1'b1;

    doc_edge_sync u_timer_edge (
        .clk_sys(clk_sys),
        .rst_sync_b(rst_sync_b_q),
        .level_async(timer_level),
        .fall_q(timer_fall)
    );

    // ======================================================================
    // control register, no unlock needed
    always_ff @(posedge clk_sys or negedge rst_sync_b_q) begin
        if (!rst_sync_b_q) begin
            ctl_q <= DOC_CTL_RESET;
        end else if (reg_wr && addr_is(reg_addr, DOC_ADDR_CONTROL)) begin
            // reserved bits are not stored, so they read back as zero
            ctl_q <= reg_wdata[DOC_CTL_W-1:0] & DOC_CTL_WR_MASK;
        end
    end

    // ======================================================================
    // unlock sequence
    assign commit_c = reg_wr && (key_q == DOC_KEY_HELD)
        && addr_is(reg_addr, DOC_ADDR_KEY_SECOND)
        && (reg_wdata[7:0] == DOC_KEY_SECOND_VAL);

    always_ff @(posedge clk_sys or negedge rst_sync_b_q) begin
        if (!rst_sync_b_q) begin
            key_q <= DOC_KEY_IDLE;
            pend_is_sample_q <= 1'b0;
            pend_data_q <= DOC_SAMPLE_RESET;
        end else if (reg_wr) begin
            // any write out of sequence abandons the unlock, except a repeated first key while armed
            case (key_q)
                DOC_KEY_IDLE: begin
                    if (addr_is(reg_addr, DOC_ADDR_KEY_FIRST)
                            && reg_wdata[7:0] == DOC_KEY_FIRST_VAL) begin
                        key_q <= DOC_KEY_ARMED;
                    end
                end
                DOC_KEY_ARMED: begin
                    if (addr_is(reg_addr, DOC_ADDR_SAMPLE)) begin
                        pend_is_sample_q <= 1'b1;
                        pend_data_q <= reg_wdata[DOC_SAMPLE_W-1:0];
                        key_q <= DOC_KEY_HELD;
                    end else if (addr_is(reg_addr, DOC_ADDR_SOURCE)) begin
                        pend_is_sample_q <= 1'b0;
                        pend_data_q <= reg_wdata[DOC_SAMPLE_W-1:0];
                        key_q <= DOC_KEY_HELD;
                    end else if (!(addr_is(reg_addr, DOC_ADDR_KEY_FIRST)
                            && reg_wdata[7:0] == DOC_KEY_FIRST_VAL)) begin
                        key_q <= DOC_KEY_IDLE;
                    end
                end
                DOC_KEY_HELD: begin
                    key_q <= DOC_KEY_IDLE;
                end
                default: begin
                    key_q <= DOC_KEY_IDLE;
                end
            endcase
        end
    end

    // ======================================================================
    // protected registers: sample word is the staging register
    always_ff @(posedge clk_sys or negedge rst_sync_b_q) begin
        if (!rst_sync_b_q) begin
            source_q <= DOC_SRC_RESET;
            sample_q <= DOC_SAMPLE_RESET;
        end else if (commit_c) begin
            if (pend_is_sample_q) begin
                sample_q <= pend_data_q[DOC_SAMPLE_W-1:0];
            end else begin
                source_q <= pend_data_q[DOC_SRC_W-1:0];
            end
        end
    end

    // ======================================================================
    // converter input
    always_ff @(posedge clk_sys or negedge rst_sync_b_q) begin
        if (!rst_sync_b_q) begin
            conv_code_q <= DOC_CODE_RESET;
        end else if (mode_active) begin
            if (!soft_sel) begin
                // synthesizer keeps its own pace whatever the rate bit says
                if (synth_valid) begin
                    conv_code_q <= to_code(synth_sample);
                end
            end else if (soft_tick) begin
                conv_code_q <= to_code(sample_q);
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rst_sync_b_q) begin
        if (!rst_sync_b_q) begin
            conv_power_q <= 1'b0;
        end else begin
            // reserved codes are treated as power-down
            conv_power_q <= mode_active;
        end
    end

    // ======================================================================
    // line driver enables, independent of the mode field
    always_ff @(posedge clk_sys or negedge rst_sync_b_q) begin
        if (!rst_sync_b_q) begin
            line_pos_oe_q <= 1'b0;
            line_neg_oe_q <= 1'b0;
        end else begin
            line_pos_oe_q <= ctl_q[DOC_CTL_OE_BIT];
            line_neg_oe_q <= ctl_q[DOC_CTL_OE_BIT] & ctl_q[DOC_CTL_DIFF_BIT];
        end
    end

    // ======================================================================
    // read port
    always_ff @(posedge clk_sys or negedge rst_sync_b_q) begin
        if (!rst_sync_b_q) begin
            reg_rdata_q <= 32'h0000_0000;
        end else begin
            reg_rdata_q <= 32'h0000_0000;
            if (reg_rd) begin
                if (addr_is(reg_addr, DOC_ADDR_SAMPLE)) begin
                    reg_rdata_q[DOC_SAMPLE_W-1:0] <= sample_q;
                end else if (addr_is(reg_addr, DOC_ADDR_SOURCE)) begin
                    reg_rdata_q[DOC_SRC_W-1:0] <= source_q;
                end else if (addr_is(reg_addr, DOC_ADDR_CONTROL)) begin
                    reg_rdata_q[DOC_CTL_W-1:0] <= ctl_q;
                end else if (addr_is(reg_addr, DOC_ADDR_STATUS)) begin
                    reg_rdata_q[DOC_SAMPLE_W-1:0] <= conv_code_q;
                    reg_rdata_q[DOC_STAT_ARMED_BIT] <= key_q == DOC_KEY_ARMED;
                    reg_rdata_q[DOC_STAT_HELD_BIT] <= key_q == DOC_KEY_HELD;
                    reg_rdata_q[DOC_STAT_ACTIVE_BIT] <= conv_power_q;
                end
            end
        end
    end

    // ======================================================================
    // checks
    default clocking doc_cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_sync_b_q);

    AST_OE_FOLLOWS_WRITE:
        assert property (reg_wr && addr_is(reg_addr, DOC_ADDR_CONTROL)
            |=> ##1 line_pos_oe_q == $past(reg_wdata[DOC_CTL_OE_BIT], 2))
        else $error("line enable does not follow control write");

    AST_OE_ANY_MODE:
        assert property (!mode_active && ctl_q[DOC_CTL_OE_BIT] |=> line_pos_oe_q)
        else $error("line enable blocked outside active mode");

    AST_NEG_NEEDS_DIFF:
        assert property (line_neg_oe_q |-> line_pos_oe_q
            && $past(ctl_q[DOC_CTL_DIFF_BIT]))
        else $error("negative pin driven without differential mode");

    AST_POWER_DOWN_CODES:
        assert property (ctl_q[DOC_CTL_MODE_HI:DOC_CTL_MODE_LO] != DOC_MODE_ACTIVE
            |=> !conv_power_q && $stable(conv_code_q))
        else $error("converter active outside mode 11");

    AST_TIMER_LOAD:
        assert property (mode_active && soft_sel && ctl_q[DOC_CTL_RATE_BIT] && timer_fall
            |=> conv_code_q == to_code($past(sample_q)))
        else $error("timer edge did not load the sample");

    AST_SYNTH_IGNORES_RATE:
        assert property (mode_active && !soft_sel && synth_valid
            |=> conv_code_q == to_code($past(synth_sample)))
        else $error("synth sample not loaded");

    AST_SYNTH_ONLY:
        assert property (mode_active && !soft_sel && !synth_valid |=> $stable(conv_code_q))
        else $error("converter changed without a synth sample");

    AST_KEYED_ONLY:
        assert property (!$stable(sample_q) || !$stable(source_q) |-> $past(commit_c))
        else $error("protected register changed without unlock");

    AST_BUS_RATE_CODING:
        assert property (mode_active && soft_sel && !ctl_q[DOC_CTL_RATE_BIT]
            |=> conv_code_q == {~$past(sample_q[9]), $past(sample_q[8:0])})
        else $error("bus-rate load or coding wrong");

    AST_STAGED_HOLD:
        assert property (mode_active && soft_sel && ctl_q[DOC_CTL_RATE_BIT] && !timer_fall
            |=> $stable(conv_code_q))
        else $error("converter changed between timer edges");

    AST_OE_OFF_RELEASES:
        assert property (!ctl_q[DOC_CTL_OE_BIT] |=> !line_pos_oe_q && !line_neg_oe_q)
        else $error("line pins driven with output enable clear");

    AST_SINGLE_ENDED:
        assert property (ctl_q[DOC_CTL_OE_BIT] && !ctl_q[DOC_CTL_DIFF_BIT]
            |=> line_pos_oe_q && !line_neg_oe_q)
        else $error("single-ended mode drives the negative pin");

    AST_POWER_ACTIVE:
        assert property (mode_active |=> conv_power_q)
        else $error("converter not powered in mode 11");

    AST_SOURCE_COMMIT:
        assert property (commit_c && !pend_is_sample_q
            |=> source_q == $past(pend_data_q[DOC_SRC_W-1:0]))
        else $error("source write not applied on the second key");

    AST_SAMPLE_COMMIT:
        assert property (commit_c && pend_is_sample_q
            |=> sample_q == $past(pend_data_q[DOC_SAMPLE_W-1:0]))
        else $error("sample write not staged on the second key");

    // third write always closes the sequence, so a stray key cannot commit later
    AST_ABORT_ON_WRITE:
        assert property (reg_wr && key_q == DOC_KEY_HELD |=> key_q == DOC_KEY_IDLE)
        else $error("unlock sequence not closed after its third write");

endmodule

// file: tb.sv
// self-checking testbench for the converter output control block
// assumes doc_pkg and doc_top are compiled first; single 40 MHz clock
`timescale 1ns/1ps
module tb;
    import doc_pkg::*;

    // ======================================================================
    // stimulus and observed signals
    logic clk_sys;
    logic rst_b;
    logic [31:0] reg_addr;
    logic [31:0] reg_wdata;
    logic reg_wr;
    logic reg_rd;
    logic [31:0] reg_rdata_q;
    logic timer_level;
    logic [9:0] synth_sample;
    logic synth_valid;
    logic [9:0] conv_code_q;
    logic conv_power_q;
    logic line_pos_oe_q;
    logic line_neg_oe_q;
    int n_mismatch;
    int num_checks;
    logic [31:0] rd_val;
    logic [9:0] held;
    // reference control lives outside this block; address arbitrary
    localparam logic [31:0] REF_CTL_ADDR = 32'hFFFF_0600;

    doc_top i_doc_top (
        .clk_sys(clk_sys), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q),
        .timer_level(timer_level), .synth_sample(synth_sample), .synth_valid(synth_valid),
        .conv_code_q(conv_code_q), .conv_power_q(conv_power_q),
        .line_pos_oe_q(line_pos_oe_q), .line_neg_oe_q(line_neg_oe_q)
    );

    always #12.5 clk_sys = ~clk_sys;

    // ======================================================================
    // compare, bus and helper tasks
    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic chk_bit(input logic got, input logic exp);
        num_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic settle(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask

    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask

    // read data stand only in the cycle after the taking edge
    task automatic rd(input logic [31:0] a, output logic [31:0] d);
        @(posedge clk_sys);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1;
        d = reg_rdata_q;
    endtask

    task automatic keyed_wr(input logic [31:0] a, input logic [31:0] d);
        wr(DOC_ADDR_KEY_FIRST, 32'h0000_0007);
        wr(a, d);
        wr(DOC_ADDR_KEY_SECOND, 32'h0000_00B9);
    endtask

    task automatic chk_pins(input logic pwr, input logic pos, input logic neg);
        chk_bit(conv_power_q, pwr);
        chk_bit(line_pos_oe_q, pos);
        chk_bit(line_neg_oe_q, neg);
    endtask

    function automatic logic [9:0] to_code(input logic [9:0] v);
        return {~v[9], v[8:0]};
    endfunction

    // ======================================================================
    // scenarios
    task automatic t_reset;
        chk_word({22'h0, conv_code_q}, 32'h0000_0200);
        chk_pins(1'b0, 1'b0, 1'b0);
        rd(DOC_ADDR_SOURCE, rd_val);
        chk_word(rd_val, 32'h0000_0000);
        rd(DOC_ADDR_CONTROL, rd_val);
        chk_word(rd_val, 32'h0000_0000);
        wr(REF_CTL_ADDR, 32'h0000_0001);
        rd(REF_CTL_ADDR, rd_val);
        chk_word(rd_val, 32'h0000_0000);
    endtask

    // enables act in modes 11, 00 and 10, reserved modes stay powered down
    task automatic t_control;
        wr(DOC_ADDR_CONTROL, 32'h0000_0037);
        rd(DOC_ADDR_CONTROL, rd_val);
        chk_word(rd_val, 32'h0000_0037);
        settle(1);
        chk_pins(1'b1, 1'b1, 1'b1);
        wr(DOC_ADDR_CONTROL, 32'h0000_0020);
        settle(2);
        chk_pins(1'b0, 1'b1, 1'b0);
        wr(DOC_ADDR_CONTROL, 32'h0000_0012);
        settle(2);
        chk_pins(1'b0, 1'b0, 1'b0);
        wr(DOC_ADDR_CONTROL, 32'h0000_0034);
        settle(2);
        chk_pins(1'b0, 1'b1, 1'b1);
    endtask

    task automatic t_direct;
        logic [9:0] codes [3];
        codes = '{10'h000, 10'h200, 10'h1FF};
        wr(DOC_ADDR_CONTROL, 32'h0000_0026);
        keyed_wr(DOC_ADDR_SOURCE, 32'h0000_0001);
        rd(DOC_ADDR_SOURCE, rd_val);
        chk_word(rd_val, 32'h0000_0001);
        foreach (codes[i]) begin
            keyed_wr(DOC_ADDR_SAMPLE, {22'h0, codes[i]});
            settle(3);
            chk_word({22'h0, conv_code_q}, {22'h0, to_code(codes[i])});
        end
        rd(DOC_ADDR_SAMPLE, rd_val);
        chk_word(rd_val, 32'h0000_01FF);
        // an unrelated write between the steps aborts the sequence
        wr(DOC_ADDR_KEY_FIRST, 32'h0000_0007);
        rd(DOC_ADDR_STATUS, rd_val);
        chk_word(rd_val, 32'h0005_03FF);
        wr(DOC_ADDR_SAMPLE, 32'h0000_0155);
        rd(DOC_ADDR_STATUS, rd_val);
        chk_word(rd_val, 32'h0006_03FF);
        wr(DOC_ADDR_CONTROL, 32'h0000_0026);
        wr(DOC_ADDR_KEY_SECOND, 32'h0000_00B9);
        settle(3);
        chk_word({22'h0, conv_code_q}, {22'h0, to_code(10'h1FF)});
        wr(DOC_ADDR_SAMPLE, 32'h0000_0155);
        settle(3);
        chk_word({22'h0, conv_code_q}, {22'h0, to_code(10'h1FF)});
    endtask

    // staged sample waits for the timer's falling edge
    task automatic t_timer;
        int k;
        wr(DOC_ADDR_CONTROL, 32'h0000_0027);
        keyed_wr(DOC_ADDR_SAMPLE, 32'h0000_0155);
        settle(8);
        chk_word({22'h0, conv_code_q}, {22'h0, to_code(10'h1FF)});
        @(posedge clk_sys);
        timer_level <= 1'b0;
        k = 0;
        while (conv_code_q === to_code(10'h1FF) && k < 12) begin
            settle(1);
            k++;
        end
        chk_word({22'h0, conv_code_q}, {22'h0, to_code(10'h155)});
        chk_bit(k >= 4 && k <= 7, 1'b1);
        @(posedge clk_sys);
        timer_level <= 1'b1;
    endtask

    task automatic pulse_synth(input logic [9:0] s);
        @(posedge clk_sys);
        synth_valid <= 1'b1;
        synth_sample <= s;
        @(posedge clk_sys);
        synth_valid <= 1'b0;
        #1;
    endtask

    // rate bit set yet synthesizer samples land one cycle after valid
    task automatic t_synth;
        keyed_wr(DOC_ADDR_SOURCE, 32'h0000_0000);
        settle(2);
        pulse_synth(10'h2AA);
        chk_word({22'h0, conv_code_q}, {22'h0, to_code(10'h2AA)});
        pulse_synth(10'h0F0);
        chk_word({22'h0, conv_code_q}, {22'h0, to_code(10'h0F0)});
        held = conv_code_q;
        wr(DOC_ADDR_CONTROL, 32'h0000_0020);
        settle(2);
        pulse_synth(10'h111);
        settle(1);
        chk_word({22'h0, conv_code_q}, {22'h0, held});
        chk_bit(conv_power_q, 1'b0);
    endtask

    // ======================================================================
    // closing and main sequence
    task automatic report_and_stop;
        $display("checks=%0d mismatches=%0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    initial begin
        clk_sys = 1'b0;
        rst_b = 1'b0;
        reg_addr = 32'h0;
        reg_wdata = 32'h0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        timer_level = 1'b1;
        synth_sample = 10'h000;
        synth_valid = 1'b0;
        n_mismatch = 0;
        num_checks = 0;
        repeat (8) @(posedge clk_sys);
        rst_b <= 1'b1;
        settle(3);
        t_reset();
        t_control();
        t_direct();
        t_timer();
        t_synth();
        report_and_stop();
    end

    // the whole sequence needs under 200 cycles
    initial begin
        repeat (5000) @(posedge clk_sys);
        n_mismatch++;
        report_and_stop();
    end
endmodule
